// File: src/tc_channel_defs.vh
`ifndef TC_CHANNEL_DEFS_VH
`define TC_CHANNEL_DEFS_VH
// register offsets (byte addresses, low 8 bits)
`define OFS_CHANNEL_COMMAND    8'h00
`define OFS_CHANNEL_MODE       8'h04
`define OFS_COUNTER_VALUE      8'h10
`define OFS_CAPTURE_COMPARE_A  8'h14
`define OFS_CAPTURE_COMPARE_B  8'h18
`define OFS_COMPARE_C          8'h1c
`define OFS_CHANNEL_STATUS     8'h20
`define OFS_IRQ_ENABLE_SET     8'h24
`define OFS_IRQ_ENABLE_CLEAR   8'h28
`define OFS_IRQ_MASK           8'h2c
`define OFS_BLOCK_COMMAND      8'hc0
`define OFS_BLOCK_CLOCK_ROUTE  8'hc4
// channel command bits
`define CMD_CLK_ENABLE   0
`define CMD_CLK_DISABLE  1
`define CMD_SW_TRIGGER   2
`define BLK_SYNC         0
// channel mode fields
`define MODE_RESET       32'h0000_0000
`define MODE_CLK_SEL_LO  0
`define MODE_CLK_SEL_HI  2
`define MODE_WAVE        15
`define CAP_EDGE_LO      8
`define CAP_EDGE_HI      9
`define CAP_TRIG_LINE    10
`define CAP_LDB_STOP     6
`define CAP_LDB_DIS      7
`define CAP_CMP_TRIG     14
`define CAP_LOAD_A_LO    16
`define CAP_LOAD_A_HI    17
`define CAP_LOAD_B_LO    18
`define CAP_LOAD_B_HI    19
`define WAV_CMP_STOP     6
`define WAV_CMP_DIS      7
`define WAV_EVT_EDGE_LO  8
`define WAV_EVT_EDGE_HI  9
`define WAV_EVT_SRC_LO   10
`define WAV_EVT_SRC_HI   11
`define WAV_EVT_TRIG_EN  12
`define WAV_SHAPE_LO     13
`define WAV_SHAPE_HI     14
`define WAV_A_CMPA       16
`define WAV_A_CMPC       18
`define WAV_A_EVT        20
`define WAV_A_SWT        22
`define WAV_B_CMPB       24
`define WAV_B_CMPC       26
`define WAV_B_EVT        28
`define WAV_B_SWT        30
// status bits
`define ST_OVERFLOW      0
`define ST_LOAD_OVERRUN  1
`define ST_CMP_A         2
`define ST_CMP_B         3
`define ST_CMP_C         4
`define ST_LOAD_A        5
`define ST_LOAD_B        6
`define ST_EXT_TRIG      7
`define ST_CLK_RUN       16
`define ST_LINE_A        17
`define ST_LINE_B        18
`define ST_IRQ_BITS      8
// count shapes
`define SHAPE_UP_MAX     2'b00
`define SHAPE_UPDN_MAX   2'b01
`define SHAPE_UP_C       2'b10
`define SHAPE_UPDN_C     2'b11
`define CNT_MAX          16'hffff
`endif

// File: src/tc_channel.v
// Notes on behaviour
// - mode bit clear selects capture mode
// - capture mode drives neither io line
// - each capture register loads on its edge
// - A loads if fresh or after B
// - B loads only after A loaded
// - unread reload overwrites and flags overrun
// - select bit picks line A or B trigger
// - trigger edge field zero disables trigger
// - mode bit set selects waveform mode
// - two pwm outputs, one-shot or repeating pulses
// - event source line B frees line B
// - compare A on A, B on B, C both
// - shape 00 counts up to max, wraps
// - shapes 00/10 reset on event or software
// - shapes 00/01 ignore compare C trigger
// - compare C may stop or disable clock
// - shape 10 counts up to C, resets
// - shape 01 counts up then down fully
// - shape 11 counts up to C then down
// - up/down trigger reverses count direction
// - event source: chained clocks or line B
// - event edge zero defines no event
// - event triggers only when enabled
// - each event sets, clears or toggles outputs
// - capture A/B writable only in waveform mode
// - any trigger starts clock, resets counter (up/down shape counting up: holds)
// - block sync bit triggers all channels
`timescale 1ns/1ps
`default_nettype none
`include "tc_channel_defs.vh"
module tc_channel (
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  input  wire        clk_en_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire        count_clk_i,
  input  wire        chained_clock_in_0_i,
  input  wire        chained_clock_in_1_i,
  input  wire        chained_clock_in_2_i,
  input  wire        io_line_a_i,
  output reg         io_line_a_o,
  output wire        io_line_a_oe_o,
  input  wire        io_line_b_i,
  output reg         io_line_b_o,
  output wire        io_line_b_oe_o,
  output wire        sync_o,
  output wire        irq_o
);

  // edge select: 01 rising, 10 falling, 11 both
  function edge_hit;
    input [1:0] sel;
    input       rise;
    input       fall;
    begin
      edge_hit = (sel[0] & rise) | (sel[1] & fall);
    end
  endfunction

  // output action: 01 set, 10 clear, 11 toggle
  function out_act;
    input [1:0] act;
    input       cur;
    begin
      case (act)
        2'b01:   out_act = 1'b1;
        2'b10:   out_act = 1'b0;
        2'b11:   out_act = ~cur;
        default: out_act = cur;
      endcase
    end
  endfunction

  reg  [31:0] mode_reg;
  reg  [15:0] cv_reg;
  reg  [15:0] ra_reg;
  reg  [15:0] rb_reg;
  reg  [15:0] rc_reg;
  reg  [7:0]  status_reg;
  reg  [7:0]  mask_reg;
  reg  [5:0]  route_reg;
  reg         clk_on_reg;
  reg         run_reg;
  reg         down_reg;
  reg         ra_done_reg;
  reg         ra_unread_reg;
  reg         rb_unread_reg;
  reg         trig_pend_reg;
  reg         cclk_d_reg;
  reg         a_d_reg;
  reg         b_d_reg;
  reg         x0_d_reg;
  reg         x1_d_reg;
  reg         x2_d_reg;

  wire wave = mode_reg[`MODE_WAVE];
  wire [1:0] shape = mode_reg[`WAV_SHAPE_HI:`WAV_SHAPE_LO];
  wire [1:0] evt_src = mode_reg[`WAV_EVT_SRC_HI:`WAV_EVT_SRC_LO];
  wire evt_on_b = wave & (evt_src == 2'b00);

  assign io_line_a_oe_o = wave;
  assign io_line_b_oe_o = wave & ~evt_on_b;

  wire wr_ccr  = wr_i & (addr_i == `OFS_CHANNEL_COMMAND);
  wire sw_trig = wr_ccr & wdata_i[`CMD_SW_TRIGGER];
  wire sync_wr = clk_en_i & wr_i & (addr_i == `OFS_BLOCK_COMMAND) & wdata_i[`BLK_SYNC];
  assign sync_o = sync_wr;

  // pins taken as synchronous; edges against last sample
  wire a_rise = io_line_a_i & ~a_d_reg;
  wire a_fall = ~io_line_a_i & a_d_reg;
  wire b_rise = io_line_b_i & ~b_d_reg;
  wire b_fall = ~io_line_b_i & b_d_reg;

  // selected clock source (internal taps collapsed onto count_clk_i)
  wire [2:0] clk_sel = mode_reg[`MODE_CLK_SEL_HI:`MODE_CLK_SEL_LO];
  reg  src_clk;
  always @* begin
    case (clk_sel)
      3'b101:  src_clk = chained_clock_in_0_i;
      3'b110:  src_clk = chained_clock_in_1_i;
      3'b111:  src_clk = chained_clock_in_2_i;
      default: src_clk = count_clk_i;
    endcase
  end
  wire tick = src_clk & ~cclk_d_reg;

  // capture external trigger
  wire cap_line_a = mode_reg[`CAP_TRIG_LINE];
  wire cap_ext = ~wave & (cap_line_a ?
      edge_hit(mode_reg[`CAP_EDGE_HI:`CAP_EDGE_LO], a_rise, a_fall) :
      edge_hit(mode_reg[`CAP_EDGE_HI:`CAP_EDGE_LO], b_rise, b_fall));

  // waveform external event
  reg ev_rise;
  reg ev_fall;
  always @* begin
    case (evt_src)
      2'b01: begin
        ev_rise = chained_clock_in_0_i & ~x0_d_reg;
        ev_fall = ~chained_clock_in_0_i & x0_d_reg;
      end
      2'b10: begin
        ev_rise = chained_clock_in_1_i & ~x1_d_reg;
        ev_fall = ~chained_clock_in_1_i & x1_d_reg;
      end
      2'b11: begin
        ev_rise = chained_clock_in_2_i & ~x2_d_reg;
        ev_fall = ~chained_clock_in_2_i & x2_d_reg;
      end
      default: begin
        ev_rise = b_rise;
        ev_fall = b_fall;
      end
    endcase
  end
  wire ext_evt = wave & edge_hit(mode_reg[`WAV_EVT_EDGE_HI:`WAV_EVT_EDGE_LO],
                                 ev_rise, ev_fall);
  wire ev_trig = ext_evt & mode_reg[`WAV_EVT_TRIG_EN];

  // compares, evaluated on the counting edge
  wire cmp_a = wave & tick & run_reg & (cv_reg == ra_reg);
  wire cmp_b = wave & tick & run_reg & (cv_reg == rb_reg);
  wire cmp_c = tick & run_reg & (cv_reg == rc_reg);
  // waveform bit 14 is a shape bit; shape 10 wraps in the counter,
  // a second trigger would hold zero a tick and defeat compare stop
  wire c_trig = ~wave & mode_reg[`CAP_CMP_TRIG] & cmp_c;

  wire any_trig = sw_trig | sync_wr | ev_trig | cap_ext | c_trig;

  // capture loads on line A edges
  wire ld_a_edge = ~wave &
      edge_hit(mode_reg[`CAP_LOAD_A_HI:`CAP_LOAD_A_LO], a_rise, a_fall);
  wire ld_b_edge = ~wave &
      edge_hit(mode_reg[`CAP_LOAD_B_HI:`CAP_LOAD_B_LO], a_rise, a_fall);
  wire load_a = ld_a_edge & ~ra_done_reg;
  wire load_b = ld_b_edge & ra_done_reg & ~load_a;

  wire c_stop = cmp_c & ((wave & mode_reg[`WAV_CMP_STOP]) |
                         (~wave & 1'b0));
  wire c_dis  = cmp_c & wave & mode_reg[`WAV_CMP_DIS];
  wire b_stop = load_b & mode_reg[`CAP_LDB_STOP];
  wire b_dis  = load_b & mode_reg[`CAP_LDB_DIS];

  wire rd_ra = rd_i & (addr_i == `OFS_CAPTURE_COMPARE_A);
  wire rd_rb = rd_i & (addr_i == `OFS_CAPTURE_COMPARE_B);
  wire rd_sr = rd_i & (addr_i == `OFS_CHANNEL_STATUS);

  wire [15:0] top = shape[1] ? rc_reg : `CNT_MAX;

  // counter next value
  reg [15:0] cv_next;
  reg        down_next;
  reg        ovf;
  always @* begin
    cv_next   = cv_reg;
    down_next = down_reg;
    ovf       = 1'b0;
    if (trig_pend_reg && tick && clk_on_reg) begin
      cv_next = 16'h0000;
      if (wave && shape[0])
        down_next = ~down_reg;
      if (wave && shape[0] && down_reg == 1'b0)
        cv_next = cv_reg;
    end else if (tick && run_reg) begin
      if (!wave || shape == `SHAPE_UP_MAX) begin
        cv_next = cv_reg + 16'h0001;
        ovf     = (cv_reg == `CNT_MAX);
      end else if (shape == `SHAPE_UP_C) begin
        cv_next = (cv_reg == rc_reg) ? 16'h0000 : cv_reg + 16'h0001;
      end else begin
        if (!down_reg && cv_reg >= top) begin
          down_next = 1'b1;
          cv_next   = cv_reg - 16'h0001;
        end else if (down_reg && cv_reg == 16'h0000) begin
          down_next = 1'b0;
          cv_next   = 16'h0001;
        end else if (down_reg) begin
          cv_next = cv_reg - 16'h0001;
        end else begin
          cv_next = cv_reg + 16'h0001;
        end
      end
    end
  end

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_reg      <= `MODE_RESET;
      cv_reg        <= 16'h0000;
      ra_reg        <= 16'h0000;
      rb_reg        <= 16'h0000;
      rc_reg        <= 16'h0000;
      status_reg    <= 8'h00;
      mask_reg      <= 8'h00;
      route_reg     <= 6'h00;
      clk_on_reg    <= 1'b0;
      run_reg       <= 1'b0;
      down_reg      <= 1'b0;
      ra_done_reg   <= 1'b0;
      ra_unread_reg <= 1'b0;
      rb_unread_reg <= 1'b0;
      trig_pend_reg <= 1'b0;
      cclk_d_reg    <= 1'b0;
      a_d_reg       <= 1'b0;
      b_d_reg       <= 1'b0;
      x0_d_reg      <= 1'b0;
      x1_d_reg      <= 1'b0;
      x2_d_reg      <= 1'b0;
      io_line_a_o   <= 1'b0;
      io_line_b_o   <= 1'b0;
      rdata_o       <= 32'h0000_0000;
    end else if (clk_en_i) begin
      cclk_d_reg <= src_clk;
      a_d_reg    <= io_line_a_i;
      b_d_reg    <= io_line_b_i;
      x0_d_reg   <= chained_clock_in_0_i;
      x1_d_reg   <= chained_clock_in_1_i;
      x2_d_reg   <= chained_clock_in_2_i;
      cv_reg     <= cv_next;
      down_reg   <= down_next;

      // trigger is applied on the next counting edge
      if (any_trig)
        trig_pend_reg <= 1'b1;
      else if (tick && clk_on_reg)
        trig_pend_reg <= 1'b0;

      // clock control: disable wins over start
      if (wr_ccr && wdata_i[`CMD_CLK_DISABLE]) begin
        clk_on_reg <= 1'b0;
        run_reg    <= 1'b0;
      end else if (c_dis || b_dis) begin
        clk_on_reg <= 1'b0;
        run_reg    <= 1'b0;
      end else if (wr_ccr && wdata_i[`CMD_CLK_ENABLE]) begin
        clk_on_reg <= 1'b1;
        if (any_trig)
          run_reg <= 1'b1;
      end else if (clk_on_reg) begin
        if (any_trig)
          run_reg <= 1'b1;
        else if (c_stop || b_stop)
          run_reg <= 1'b0;
      end

      // capture state per trigger window
      if (any_trig && !wave)
        ra_done_reg <= 1'b0;
      else if (load_a)
        ra_done_reg <= 1'b1;
      else if (load_b)
        ra_done_reg <= 1'b0;

      if (load_a)
        ra_reg <= cv_reg;
      else if (wave && wr_i && addr_i == `OFS_CAPTURE_COMPARE_A)
        ra_reg <= wdata_i[15:0];
      if (load_b)
        rb_reg <= cv_reg;
      else if (wave && wr_i && addr_i == `OFS_CAPTURE_COMPARE_B)
        rb_reg <= wdata_i[15:0];
      if (wr_i && addr_i == `OFS_COMPARE_C)
        rc_reg <= wdata_i[15:0];

      // set wins over read-clear
      ra_unread_reg <= load_a | (ra_unread_reg & ~rd_ra);
      rb_unread_reg <= load_b | (rb_unread_reg & ~rd_rb);

      status_reg <= (rd_sr ? 8'h00 : status_reg) | {
        cap_ext | ev_trig,
        load_b,
        load_a,
        cmp_c,
        cmp_b,
        cmp_a,
        (load_a & ra_unread_reg) | (load_b & rb_unread_reg),
        ovf};

      if (wr_i && addr_i == `OFS_CHANNEL_MODE)
        mode_reg <= wdata_i;
      if (wr_i && addr_i == `OFS_BLOCK_CLOCK_ROUTE)
        route_reg <= wdata_i[5:0];
      if (wr_i && addr_i == `OFS_IRQ_ENABLE_SET)
        mask_reg <= mask_reg | wdata_i[7:0];
      else if (wr_i && addr_i == `OFS_IRQ_ENABLE_CLEAR)
        mask_reg <= mask_reg & ~wdata_i[7:0];

      // output controller, software trigger lowest priority
      if (wave) begin
        io_line_a_o <= out_act(cmp_a ? mode_reg[`WAV_A_CMPA+1:`WAV_A_CMPA] :
                       cmp_c ? mode_reg[`WAV_A_CMPC+1:`WAV_A_CMPC] :
                       ext_evt ? mode_reg[`WAV_A_EVT+1:`WAV_A_EVT] :
                       (sw_trig | sync_wr) ? mode_reg[`WAV_A_SWT+1:`WAV_A_SWT] :
                       2'b00, io_line_a_o);
        if (!evt_on_b)
          io_line_b_o <= out_act(cmp_b ? mode_reg[`WAV_B_CMPB+1:`WAV_B_CMPB] :
                         cmp_c ? mode_reg[`WAV_B_CMPC+1:`WAV_B_CMPC] :
                         ext_evt ? mode_reg[`WAV_B_EVT+1:`WAV_B_EVT] :
                         (sw_trig | sync_wr) ? mode_reg[`WAV_B_SWT+1:`WAV_B_SWT] :
                         2'b00, io_line_b_o);
      end

      if (rd_i) begin
        case (addr_i)
          `OFS_CHANNEL_MODE:      rdata_o <= mode_reg;
          `OFS_COUNTER_VALUE:     rdata_o <= {16'h0000, cv_reg};
          `OFS_CAPTURE_COMPARE_A: rdata_o <= {16'h0000, ra_reg};
          `OFS_CAPTURE_COMPARE_B: rdata_o <= {16'h0000, rb_reg};
          `OFS_COMPARE_C:         rdata_o <= {16'h0000, rc_reg};
          `OFS_CHANNEL_STATUS:    rdata_o <= {13'h0, io_line_b_i, io_line_a_i,
                                              run_reg, 8'h00, status_reg};
          `OFS_IRQ_MASK:          rdata_o <= {24'h000000, mask_reg};
          `OFS_BLOCK_CLOCK_ROUTE: rdata_o <= {26'h0, route_reg};
          default:                rdata_o <= 32'h0000_0000;
        endcase
      end else begin
        rdata_o <= 32'h0000_0000;
      end
    end
  end

  // status cleared by reading, so the line drops after service
  assign irq_o = |(status_reg & mask_reg);

endmodule // tc_channel
`default_nettype wire

// File: bench/tc_channel_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tc_channel_props (
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        clk_en_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        io_line_a_oe_o,
  input wire logic        io_line_b_oe_o,
  input wire logic        sync_o,
  input wire logic        irq_o
);
  logic [31:0] mode_reg;
  logic [7:0]  mask_reg;
  logic [15:0] c_reg;
  wire         wr_ok = wr_i && clk_en_i;
  // shadow copies of the writable state the outputs depend on
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_reg <= 32'h0;
      mask_reg <= 8'h0;
      c_reg    <= 16'h0;
    end else if (wr_ok) begin
      if (addr_i == 8'h04) mode_reg <= wdata_i;
      if (addr_i == 8'h1c) c_reg <= wdata_i[15:0];
      if (addr_i == 8'h24) mask_reg <= mask_reg | wdata_i[7:0];
      if (addr_i == 8'h28) mask_reg <= mask_reg & ~wdata_i[7:0];
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rd(a);
    rd_i && clk_en_i && addr_i == a;
  endsequence
  property p_cap_a; !mode_reg[15] |-> !io_line_a_oe_o; endproperty
  property p_cap_b; !mode_reg[15] |-> !io_line_b_oe_o; endproperty
  property p_wav_a; mode_reg[15] |-> io_line_a_oe_o; endproperty
  property p_evt_b;
    mode_reg[15] |-> io_line_b_oe_o == (mode_reg[11:10] != 2'b00);
  endproperty
  property p_sync; sync_o == (wr_ok && addr_i == 8'hc0 && wdata_i[0]); endproperty
  property p_irq; mask_reg == 8'h0 |-> !irq_o; endproperty
  property p_mask; s_rd(8'h2c) |=> rdata_o == {24'h0, $past(mask_reg)}; endproperty
  property p_rc; s_rd(8'h1c) |=> rdata_o == {16'h0, $past(c_reg)}; endproperty
  a_cap_a: assert property (p_cap_a) else $error("line a driven in capture mode");
  a_cap_b: assert property (p_cap_b) else $error("line b driven in capture mode");
  a_wav_a: assert property (p_wav_a) else $error("line a not driven in waveform");
  a_evt_b: assert property (p_evt_b) else $error("line b enable wrong");
  a_sync: assert property (p_sync) else $error("sync pulse wrong");
  a_irq: assert property (p_irq) else $error("irq while fully masked");
  a_mask: assert property (p_mask) else $error("mask readback wrong");
  a_rc: assert property (p_rc) else $error("compare c readback wrong");
endmodule // tc_channel_props
bind tc_channel tc_channel_props u_props (.sys_clk_i, .sys_rst_i, .clk_en_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .io_line_a_oe_o, .io_line_b_oe_o, .sync_o, .irq_o);
`default_nettype wire

// File: bench/io_line_partner.sv
`timescale 1ns/1ps
`default_nettype none
module io_line_partner (
  input  wire logic dut_a_i,
  input  wire logic dut_a_oe_i,
  input  wire logic dut_b_i,
  input  wire logic dut_b_oe_i,
  input  wire logic want_a_i,
  input  wire logic want_b_i,
  output wire logic line_a_o,
  output wire logic line_b_o
);
  // far side yields each line while the channel drives it
  assign line_a_o = dut_a_oe_i ? dut_a_i : want_a_i;
  assign line_b_o = dut_b_oe_i ? dut_b_i : want_b_i;
endmodule // io_line_partner
`default_nettype wire

// File: bench/tc_channel_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tc_channel_tb;
  logic        sys_clk_i   = 1'b0;
  logic        sys_rst_i   = 1'b1;
  logic [7:0]  addr_i      = 8'h00;
  logic [31:0] wdata_i     = 32'h0;
  logic        wr_i        = 1'b0;
  logic        rd_i        = 1'b0;
  logic        count_clk_i = 1'b0;
  logic        want_a      = 1'b0;
  logic        want_b      = 1'b0;
  logic        chain_0     = 1'b0;
  logic [31:0] v;
  int          n_errors    = 0;
  int          n_checks    = 0;
  wire  [31:0] rdata_o;
  wire         line_a, line_b, out_a, out_b, oe_a, oe_b, sync_o, irq_o;
  tc_channel dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .count_clk_i(count_clk_i), .chained_clock_in_0_i(chain_0),
    .chained_clock_in_1_i(1'b0), .chained_clock_in_2_i(1'b0),
    .io_line_a_i(line_a), .io_line_a_o(out_a), .io_line_a_oe_o(oe_a),
    .io_line_b_i(line_b), .io_line_b_o(out_b), .io_line_b_oe_o(oe_b),
    .sync_o(sync_o), .irq_o(irq_o));
  io_line_partner far (.dut_a_i(out_a), .dut_a_oe_i(oe_a), .dut_b_i(out_b),
    .dut_b_oe_i(oe_b), .want_a_i(want_a), .want_b_i(want_b), .line_a_o(line_a),
    .line_b_o(line_b));
  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i   <= 1'b0;
    @(negedge sys_clk_i);
    d = rdata_o;
  endtask
  // each pulse is held two cycles so the sampler sees it
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      count_clk_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      count_clk_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
    end
  endtask
  task automatic settle;
    repeat (4) @(negedge sys_clk_i);
  endtask
  task automatic t_regs;
    logic [7:0] adr [0:7];
    adr = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h2c, 8'h08};
    foreach (adr[i]) begin
      rd(adr[i], v);
      chk(v, 32'h0);
    end
    $display("reset values done");
  endtask
  task automatic t_up_max;
    wr(8'h04, 32'h0000_8000);
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h4);
    tick(5);
    rd(8'h10, v);
    chk(v, 32'h4);
    wr(8'h00, 32'h4);
    tick(1);
    rd(8'h10, v);
    chk(v, 32'h0);
    tick(3);
    wr(8'hc0, 32'h1);
    tick(1);
    rd(8'h10, v);
    chk(v, 32'h0);
    $display("count up to max done");
  endtask
  task automatic t_up_c;
    wr(8'h1c, 32'h3);
    wr(8'h04, 32'h0000_c000);
    wr(8'h00, 32'h4);
    tick(6);
    rd(8'h10, v);
    chk(v, 32'h1);
    wr(8'h04, 32'h0000_c040);
    wr(8'h00, 32'h4);
    tick(6);
    rd(8'h10, v);
    chk(v, 32'h0);
    rd(8'h20, v);
    chk(v & 32'h1_0000, 32'h0);
    $display("count up to c done");
  endtask
  task automatic t_updown;
    wr(8'h1c, 32'h2);
    wr(8'h04, 32'h0000_e000);
    wr(8'h00, 32'h4);
    tick(4);
    rd(8'h10, v);
    chk(v, 32'h1);
    tick(2);
    wr(8'h00, 32'h4);
    tick(2);
    rd(8'h10, v);
    chk(v, 32'h0);
    $display("up down done");
  endtask
  task automatic t_wave;
    wr(8'h1c, 32'h4);
    wr(8'h04, 32'h0909_c400);
    wr(8'h14, 32'h2);
    wr(8'h18, 32'h3);
    wr(8'h00, 32'h4);
    for (int i = 0; i < 6; i++) begin
      tick(1);
      chk({30'h0, out_a, out_b}, (i == 3) ? 32'h2 : (i == 4) ? 32'h3 : 32'h0);
    end
    wr(8'h04, 32'h0909_c000);
    settle;
    chk({30'h0, oe_a, oe_b}, 32'h2);
    $display("waveform outputs done");
  endtask
  task automatic t_event;
    wr(8'h04, 32'h0090_9500);
    tick(2);
    chain_0 <= 1'b1;
    settle;
    chk({31'h0, out_a}, 32'h1);
    tick(1);
    rd(8'h10, v);
    chk(v, 32'h0);
    rd(8'h20, v);
    chk(v & 32'h80, 32'h80);
    @(posedge sys_clk_i);
    chain_0 <= 1'b0;
    wr(8'h00, 32'h4);
    settle;
    chk({31'h0, out_a}, 32'h0);
    wr(8'h04, 32'h0090_9400);
    chain_0 <= 1'b1;
    settle;
    chk({31'h0, out_a}, 32'h0);
    tick(1);
    wr(8'h04, 32'h0090_8500);
    chain_0 <= 1'b0;
    tick(2);
    chain_0 <= 1'b1;
    tick(1);
    rd(8'h10, v);
    chk(v, 32'h3);
    $display("external event done");
  endtask
  task automatic pulse_a(input logic [31:0] m);
    wr(8'h04, m);
    want_a <= 1'b0;
    settle;
    @(posedge sys_clk_i);
    want_a <= 1'b1;
    settle;
    rd(8'h20, v);
  endtask
  task automatic t_capture;
    wr(8'h04, 32'h0);
    want_a <= 1'b1;
    settle;
    wr(8'h04, 32'h0009_0000);
    wr(8'h00, 32'h4);
    tick(3);
    want_a <= 1'b0;
    settle;
    tick(1);
    want_a <= 1'b1;
    settle;
    tick(1);
    want_a <= 1'b0;
    settle;
    tick(1);
    want_a <= 1'b1;
    settle;
    wr(8'h14, 32'h1234);
    wr(8'h24, 32'h2);
    settle;
    chk({31'h0, irq_o}, 32'h1);
    wr(8'h28, 32'h2);
    settle;
    chk({31'h0, irq_o}, 32'h0);
    rd(8'h20, v);
    chk(v & 32'h82, 32'h2);
    rd(8'h14, v);
    chk(v, 32'h5);
    rd(8'h18, v);
    chk(v, 32'h4);
    pulse_a(32'h0000_0500);
    chk(v & 32'h80, 32'h80);
    pulse_a(32'h0000_0100);
    chk(v & 32'h80, 32'h0);
    pulse_a(32'h0000_0400);
    chk(v & 32'h80, 32'h0);
    $display("capture done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    t_regs;
    t_up_max;
    t_up_c;
    t_updown;
    t_wave;
    t_event;
    t_capture;
    report_and_stop;
  end
  // whole run is well under a thousand cycles
  initial begin
    #500000;
    n_errors++;
    report_and_stop;
  end
endmodule // tc_channel_tb
`default_nettype wire
